// ===== hw/plug_cfg_regs.vh
`ifndef PLUG_CFG_REGS_VH
`define PLUG_CFG_REGS_VH
// ==========================================================
// Register offsets (byte addresses)
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_LOCAL_CFG 12'h008
`define REG_CABLE_CFG 12'h00C
`define REG_SINK_PDO 12'h010
`define REG_REQ_OBJ 12'h014
`define REG_EXT_ID0 12'h018
`define REG_EXT_ID1 12'h01C
`define REG_EXT_VER 12'h020
// ==========================================================
// Field positions and values
`define SRC_CAP_DRD_BIT 25
`define CTRL_WDOG_EN_BIT 0
`define CTRL_REPEAT_GAP_LSB 16
`define FIXED_5V_50MV 10'b00_0110_0100
`define EXT_BLOCK_VERSION 8'h01
`define REQ_OBJ_POSITION 3'b001
`define DR_SWAP_RETRIES 2'd3
// ==========================================================
// Timing (microseconds) and reset values
`define T_SRC_DISCONNECT_US 2
`define T_SINK_WAIT_CAP_US 620000
`define T_HANDSHAKE_US 100000
`define T_DR_SWAP_WAIT_US 100000
`define T_WATCHDOG_US 50000
`define CLK_MHZ 100
`define REPEAT_GAP_RESET 16'h2710
`endif

// ===== hw/plug_cfg_fsm.v
`timescale 1ns/1ps
`include "plug_cfg_regs.vh"
// Behaviour
// - Master config message in initial contract or swap forces detach, then detached
// - Forced detach opens CC and VCONN for at least the disconnect time
// - Config message in remote handshake moves to repeated reporting
// - Repeated reporting keeps sending local port configuration to master
// - Only the release-capabilities ack leaves repeated reporting for contract
// - Phase-3 contract acknowledges local source capabilities with GoodCRC
// - Dual-role-data flag taken from bit 25 of source capabilities
// - Answer with 5 V zero-current request, complete explicit contract
// - Master downstream and slave upstream goes to final verification
// - Master upstream and slave downstream goes to phase-3 swap
// - Phase-3 swap sends DR_Swap to local port
// - Successful swap proceeds to final verification
// - Failed swap enters billboard-only error
// - Any local DR_Swap reject enters billboard-only error
// - Both error states show invalid-configuration billboard
// - Full-reset error shows billboard then sends Hard_Reset locally
// - Error states left only by reset (VCONN removal)
// - Watchdog on replies from far plug leads to error
// - Watchdog disabled in repeated reporting state
// - Final verification compares the current cable config value to local config
// - Match enters Rx.Detect and starts link training
// - Mismatch goes to full-reset error
// - Two power contracts: first connection and after roles settle
// - Hard Reset for capabilities only after sink wait time elapses
// - Initial sink object: fixed supply, 5 V in 50 mV steps
// - Extended block: vendor, product, assigned id, firmware, hardware bytes
// - Block version byte 1, bytes 11 to 20 zero
// - Initial request: position 1, bits 25 and 24 set, currents zero
module plug_cfg_fsm #(
  parameter SINK_WAIT_US = `T_SINK_WAIT_CAP_US,
  parameter HANDSHAKE_US = `T_HANDSHAKE_US,
  parameter SWAP_WAIT_US = `T_DR_SWAP_WAIT_US,
  parameter WATCHDOG_US = `T_WATCHDOG_US
) (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire vconn_present,
  input wire vbus_present,
  input wire cable_configuration_message,
  input wire [31:0] cable_config_value,
  input wire release_capabilities_ack_message,
  input wire dr_swap_init_message,
  input wire master_is_dfp,
  input wire far_reply,
  input wire src_caps_valid,
  input wire [31:0] src_caps_object,
  input wire contract_done,
  input wire swap_accept,
  input wire swap_reject,
  input wire swap_wait,
  output reg cable_config_send,
  output reg [31:0] cable_config_out,
  output reg port_caps_send,
  output reg good_crc_send,
  output reg request_send,
  output reg [31:0] request_object,
  output reg [31:0] sink_pdo,
  output reg dr_swap_send,
  output reg swap_accept_send,
  output reg swap_reject_send,
  output reg hard_reset_send,
  output reg billboard_invalid,
  output reg cc_open,
  output reg vconn_open,
  output reg rx_detect_start,
  output reg local_drd
);
  // ========================================================
  // States and timing
  localparam [3:0] ST_DETACHED = 4'd0;
  localparam [3:0] ST_HANDSHAKE = 4'd1;
  localparam [3:0] ST_INIT_CONTRACT = 4'd2;
  localparam [3:0] ST_DR_SWAP = 4'd3;
  localparam [3:0] ST_FORCE_DETACH = 4'd4;
  localparam [3:0] ST_REPEAT_CFG = 4'd5;
  localparam [3:0] ST_PH3_CONTRACT = 4'd6;
  localparam [3:0] ST_ERR_BB = 4'd7;
  localparam [3:0] ST_PH3_SWAP = 4'd8;
  localparam [3:0] ST_ERR_RESET = 4'd9;
  localparam [3:0] ST_VERIFY = 4'd10;
  localparam [3:0] ST_RX_DETECT = 4'd11;
  localparam integer DISC_CYC = `T_SRC_DISCONNECT_US * `CLK_MHZ;
  localparam integer WAIT_CAP_CYC = SINK_WAIT_US * `CLK_MHZ;
  localparam integer HS_CYC = HANDSHAKE_US * `CLK_MHZ;
  localparam integer SWAP_CYC = SWAP_WAIT_US * `CLK_MHZ;
  localparam integer WDOG_CYC = WATCHDOG_US * `CLK_MHZ;

  reg [3:0] state;
  reg [3:0] next_state;
  reg [31:0] timer;
  reg [31:0] cap_timer;
  reg [31:0] wdog;
  reg [15:0] gap_cnt;
  reg [1:0] retries;
  reg contract_phase;
  reg caps_seen;
  reg swap_pending;
  reg [1:0] err_step;
  reg wdog_en;
  reg [15:0] repeat_gap;
  reg [31:0] local_cfg;
  reg [31:0] sticky_cfg;
  reg [15:0] ext_vendor;
  reg [15:0] ext_product;
  reg [31:0] assigned_product_identifier;
  reg [7:0] ext_fw_ver;
  reg [7:0] ext_hw_ver;
  reg wdog_fire;

  wire ce = clk_en;
  wire entering = (next_state != state);
  wire wr_ok = psel & penable & pwrite & ce;
  // Watchdog runs only where a far reply is awaited; never while reporting
  wire wdog_active = wdog_en & (state == ST_DR_SWAP);

  // ========================================================
  // APB slave, always zero wait state
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always @* begin
    case (paddr)
      `REG_CTRL: prdata = {repeat_gap, 15'h0000, wdog_en};
      `REG_STATUS: prdata = {16'h0000, 2'b00, err_step, retries, contract_phase,
                             local_drd, 4'h0, state};
      `REG_LOCAL_CFG: prdata = local_cfg;
      `REG_CABLE_CFG: prdata = sticky_cfg;
      `REG_SINK_PDO: prdata = sink_pdo;
      `REG_REQ_OBJ: prdata = request_object;
      `REG_EXT_ID0: prdata = {ext_product, ext_vendor};
      `REG_EXT_ID1: prdata = assigned_product_identifier;
      // Version word holds bytes 8..11; bytes 11..20 are constant zero
      `REG_EXT_VER: prdata = {8'h00, `EXT_BLOCK_VERSION, ext_hw_ver, ext_fw_ver};
      default: prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_en <= 1'b1;
      repeat_gap <= `REPEAT_GAP_RESET;
      local_cfg <= 32'h0000_0000;
      ext_vendor <= 16'h0000;
      ext_product <= 16'h0000;
      assigned_product_identifier <= 32'h0000_0000;
      ext_fw_ver <= 8'h00;
      ext_hw_ver <= 8'h00;
    end else if (wr_ok) begin
      case (paddr)
        `REG_CTRL: begin
          wdog_en <= pwdata[`CTRL_WDOG_EN_BIT];
          repeat_gap <= pwdata[`CTRL_REPEAT_GAP_LSB +: 16];
        end
        `REG_LOCAL_CFG: local_cfg <= pwdata;
        `REG_EXT_ID0: begin
          ext_vendor <= pwdata[15:0];
          ext_product <= pwdata[31:16];
        end
        `REG_EXT_ID1: assigned_product_identifier <= pwdata;
        `REG_EXT_VER: begin
          ext_fw_ver <= pwdata[7:0];
          ext_hw_ver <= pwdata[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================
  // Next state
  always @* begin
    next_state = state;
    case (state)
      ST_DETACHED: if (vconn_present) next_state = ST_HANDSHAKE;
      ST_HANDSHAKE: begin
        if (cable_configuration_message) next_state = ST_REPEAT_CFG;
        else if (timer >= HS_CYC) next_state = ST_INIT_CONTRACT;
      end
      ST_INIT_CONTRACT: begin
        if (cable_configuration_message) next_state = ST_FORCE_DETACH;
        else if (dr_swap_init_message) next_state = ST_DR_SWAP;
      end
      ST_DR_SWAP: begin
        if (cable_configuration_message) next_state = ST_FORCE_DETACH;
        else if (swap_reject) next_state = ST_ERR_BB;
        else if (wdog_fire) next_state = ST_ERR_RESET;
        else if (swap_wait && retries == `DR_SWAP_RETRIES) next_state = ST_ERR_BB;
      end
      // Hold open terminations for the full disconnect interval
      ST_FORCE_DETACH: if (timer >= DISC_CYC) next_state = ST_DETACHED;
      ST_REPEAT_CFG: if (release_capabilities_ack_message) next_state = ST_PH3_CONTRACT;
      ST_PH3_CONTRACT: begin
        if (contract_done && caps_seen) begin
          if (master_is_dfp) next_state = ST_VERIFY;
          else next_state = ST_PH3_SWAP;
        end
      end
      ST_PH3_SWAP: begin
        if (swap_accept) next_state = ST_VERIFY;
        else if (swap_reject) next_state = ST_ERR_BB;
        else if (swap_wait && retries == `DR_SWAP_RETRIES) next_state = ST_ERR_BB;
      end
      ST_VERIFY: begin
        if (cable_config_value == local_cfg) next_state = ST_RX_DETECT;
        else next_state = ST_ERR_RESET;
      end
      ST_ERR_BB: next_state = ST_ERR_BB;
      ST_ERR_RESET: next_state = ST_ERR_RESET;
      ST_RX_DETECT: next_state = ST_RX_DETECT;
      default: next_state = ST_DETACHED;
    endcase
  end

  // ========================================================
  // Sequencing and message strobes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_DETACHED;
      timer <= 32'h0000_0000;
      cap_timer <= 32'h0000_0000;
      wdog <= 32'h0000_0000;
      wdog_fire <= 1'b0;
      gap_cnt <= 16'h0000;
      retries <= 2'b00;
      contract_phase <= 1'b0;
      caps_seen <= 1'b0;
      swap_pending <= 1'b0;
      err_step <= 2'b00;
      sticky_cfg <= 32'h0000_0000;
      cable_config_send <= 1'b0;
      cable_config_out <= 32'h0000_0000;
      port_caps_send <= 1'b0;
      good_crc_send <= 1'b0;
      request_send <= 1'b0;
      request_object <= 32'h0000_0000;
      sink_pdo <= 32'h0000_0000;
      dr_swap_send <= 1'b0;
      swap_accept_send <= 1'b0;
      swap_reject_send <= 1'b0;
      hard_reset_send <= 1'b0;
      billboard_invalid <= 1'b0;
      cc_open <= 1'b0;
      vconn_open <= 1'b0;
      rx_detect_start <= 1'b0;
      local_drd <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      timer <= entering ? 32'h0000_0000 : timer + 32'h0000_0001;
      cable_config_send <= 1'b0;
      port_caps_send <= 1'b0;
      good_crc_send <= 1'b0;
      request_send <= 1'b0;
      dr_swap_send <= 1'b0;
      swap_accept_send <= 1'b0;
      swap_reject_send <= 1'b0;
      hard_reset_send <= 1'b0;
      rx_detect_start <= 1'b0;
      cc_open <= (next_state == ST_FORCE_DETACH);
      vconn_open <= (next_state == ST_FORCE_DETACH);
      // Fixed supply, 5 V, no role or swap flags; comm and DRD left zero
      sink_pdo <= {2'b00, 5'h00, 2'b00, 3'b000, `FIXED_5V_50MV, 10'h000};
      if (cable_configuration_message) sticky_cfg <= cable_config_value;
      // Sink-wait timer restarts whenever VBUS drops
      if (!vbus_present) cap_timer <= 32'h0000_0000;
      else if (!caps_seen && cap_timer < WAIT_CAP_CYC) cap_timer <= cap_timer + 32'h0000_0001;
      if (vbus_present && !caps_seen && cap_timer == WAIT_CAP_CYC - 1 &&
          (state == ST_INIT_CONTRACT || state == ST_PH3_CONTRACT)) begin
        hard_reset_send <= 1'b1;
        cap_timer <= 32'h0000_0000;
      end
      if (state == ST_INIT_CONTRACT || state == ST_PH3_CONTRACT) begin
        if (src_caps_valid && !caps_seen) begin
          good_crc_send <= 1'b1;
          local_drd <= src_caps_object[`SRC_CAP_DRD_BIT];
          request_send <= 1'b1;
          request_object <= {1'b0, `REQ_OBJ_POSITION, 2'b00, 2'b11, 1'b0, 3'b000,
                             10'h000, 10'h000};
          caps_seen <= 1'b1;
        end
        if (contract_done && caps_seen) contract_phase <= 1'b1;
      end
      if (state == ST_INIT_CONTRACT && caps_seen) port_caps_send <= 1'b1;
      if (state == ST_REPEAT_CFG) begin
        if (gap_cnt == 16'h0000) begin
          cable_config_send <= 1'b1;
          cable_config_out <= local_cfg;
          gap_cnt <= repeat_gap;
        end else begin
          gap_cnt <= gap_cnt - 16'h0001;
        end
      end else begin
        gap_cnt <= 16'h0000;
      end
      // Second contract: renegotiate once phase-3 is entered
      if (next_state == ST_PH3_CONTRACT && entering) caps_seen <= 1'b0;
      if ((next_state == ST_DR_SWAP || next_state == ST_PH3_SWAP) && entering) begin
        dr_swap_send <= 1'b1;
        retries <= 2'b00;
        swap_pending <= 1'b0;
      end else if (state == ST_DR_SWAP || state == ST_PH3_SWAP) begin
        if (swap_wait && retries != `DR_SWAP_RETRIES) begin
          swap_pending <= 1'b1;
          retries <= retries + 2'b01;
        end
        if (swap_pending && timer >= SWAP_CYC) begin
          dr_swap_send <= 1'b1;
          swap_pending <= 1'b0;
        end
        if (state == ST_DR_SWAP && swap_accept) swap_accept_send <= 1'b1;
        if (state == ST_DR_SWAP && swap_reject) swap_reject_send <= 1'b1;
      end
      if (swap_wait) timer <= 32'h0000_0000;
      // Watchdog restarts on every far reply
      if (!wdog_active || far_reply || entering) begin
        wdog <= 32'h0000_0000;
        wdog_fire <= 1'b0;
      end else if (wdog >= WDOG_CYC) begin
        wdog_fire <= 1'b1;
      end else begin
        wdog <= wdog + 32'h0000_0001;
      end
      if (next_state == ST_ERR_BB || next_state == ST_ERR_RESET)
        billboard_invalid <= 1'b1;
      // Billboard first, Hard_Reset one cycle later, then hold
      if (state == ST_ERR_RESET) begin
        if (err_step == 2'b00) begin
          hard_reset_send <= 1'b1;
          err_step <= 2'b01;
        end
      end
      if (next_state == ST_RX_DETECT && entering) rx_detect_start <= 1'b1;
    end
  end
endmodule // plug_cfg_fsm

// ===== verif/plug_cfg_fsm_asserts.sv
`timescale 1ns/1ps
// ====================
// Port checks on the slave plug sequencer
module plug_cfg_fsm_asserts (
  input wire pclk,
  input wire presetn,
  input wire [31:0] src_caps_object,
  input wire good_crc_send,
  input wire request_send,
  input wire [31:0] request_object,
  input wire [31:0] sink_pdo,
  input wire local_drd,
  input wire swap_reject,
  input wire hard_reset_send,
  input wire billboard_invalid,
  input wire cc_open,
  input wire vconn_open,
  input wire rx_detect_start
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire drd_in;
  logic [9:0] open_cnt;
  assign drd_in = src_caps_object[25];
  // Open-time counter; sized well past the hold so it cannot wrap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) open_cnt <= 10'h000;
    else if (cc_open) open_cnt <= open_cnt + 10'h001;
    else open_cnt <= 10'h000;
  end
  sequence s_full_reset;
    $rose(billboard_invalid) ##1 hard_reset_send;
  endsequence
  sequence s_reply;
    good_crc_send && request_send;
  endsequence
  a_sink_object: assert property ($past(presetn) |-> sink_pdo == 32'h0001_9000)
    else $error("sink object wrong");
  a_reply_pair: assert property (good_crc_send |-> s_reply)
    else $error("ack without request");
  a_drd_flag: assert property (good_crc_send |-> local_drd == $past(drd_in))
    else $error("data role flag wrong");
  a_request_word: assert property (request_send |-> ##1 request_object == 32'h1300_0000)
    else $error("request object wrong");
  a_hard_after_bb: assert property (hard_reset_send && billboard_invalid |-> $past(billboard_invalid))
    else $error("hard reset before billboard");
  a_one_hard_reset: assert property (s_full_reset |=> !hard_reset_send && billboard_invalid)
    else $error("hard reset repeated");
  a_error_sticky: assert property (billboard_invalid |=> billboard_invalid)
    else $error("error state left");
  a_detach_hold: assert property ($fell(cc_open) |-> open_cnt >= 10'h0C8)
    else $error("detach too short");
  a_open_pair: assert property (cc_open == vconn_open)
    else $error("terminations differ");
  a_reject_error: assert property (swap_reject |-> ##[1:2] billboard_invalid)
    else $error("reject without billboard");
  a_rx_clean: assert property (rx_detect_start |-> !billboard_invalid)
    else $error("link start in error");
endmodule // plug_cfg_fsm_asserts

// ===== verif/local_port_model.sv
`timescale 1ns/1ps
// ====================
// Local source port answering the plug
module local_port_model (
  input wire pclk,
  input wire request_send,
  input wire dr_swap_send,
  input wire [1:0] mode,
  input wire slow,
  output logic contract_done = 1'b0,
  output logic swap_accept = 1'b0,
  output logic swap_reject = 1'b0,
  output logic swap_wait = 1'b0
);
  // Slow answers stress the waits on the plug side
  always @(posedge pclk) begin
    if (request_send) begin
      repeat (slow ? 6 : 1) @(posedge pclk);
      contract_done <= 1'b1;
      @(posedge pclk);
      contract_done <= 1'b0;
    end
  end
  always @(posedge pclk) begin
    if (dr_swap_send) begin
      repeat (slow ? 6 : 1) @(posedge pclk);
      swap_accept <= (mode == 2'h0);
      swap_reject <= (mode == 2'h1);
      swap_wait <= (mode == 2'h2);
      @(posedge pclk);
      {swap_accept, swap_reject, swap_wait} <= 3'h0;
    end
  end
endmodule // local_port_model

// ===== verif/cable_slave_plug_config_fsm_tb.sv
`timescale 1ns/1ps
// ====================
// Scoreboard bench for the slave plug sequencer
module cable_slave_plug_config_fsm_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic vconn = 1'b0;
  logic vbus = 1'b0;
  logic ce = 1'b1;
  logic dfp = 1'b0;
  logic slow = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [4:0] ev = 5'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] cfg_val = 32'h0000_0000;
  logic [31:0] caps = 32'h0000_0000;
  logic [31:0] loc;
  logic [31:0] eq_c[$], eq_v[$], rq[$], rm[$];
  int n_fail = 0;
  int n_compared = 0;
  int gap, last, cyc;
  wire [31:0] prdata, cfg_out;
  wire pready, cfg_send, crc, req, drs, hrs, bb, cc, rx, drd, cdone, acc, rej, wt;
  always #5 pclk = ~pclk;
  plug_cfg_fsm #(.SINK_WAIT_US(10), .HANDSHAKE_US(2), .SWAP_WAIT_US(1), .WATCHDOG_US(5)) uut (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .vconn_present(vconn), .vbus_present(vbus),
    .cable_configuration_message(ev[0]), .cable_config_value(cfg_val),
    .release_capabilities_ack_message(ev[1]), .dr_swap_init_message(ev[2]),
    .master_is_dfp(dfp), .far_reply(ev[3]), .src_caps_valid(ev[4]), .src_caps_object(caps),
    .contract_done(cdone), .swap_accept(acc), .swap_reject(rej), .swap_wait(wt),
    .cable_config_send(cfg_send), .cable_config_out(cfg_out), .port_caps_send(),
    .good_crc_send(crc), .request_send(req), .request_object(), .sink_pdo(),
    .dr_swap_send(drs), .swap_accept_send(), .swap_reject_send(), .hard_reset_send(hrs),
    .billboard_invalid(bb), .cc_open(cc), .vconn_open(), .rx_detect_start(rx),
    .local_drd(drd));
  local_port_model peer (.pclk(pclk), .request_send(req), .dr_swap_send(drs), .mode(mode),
    .slow(slow), .contract_done(cdone), .swap_accept(acc), .swap_reject(rej), .swap_wait(wt));
  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (e !== g) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic seen(logic [31:0] c, logic [31:0] v);
    if (eq_c.size() == 0) cmp("spare event", 0, c);
    else begin
      cmp("event", eq_c.pop_front(), c);
      cmp("event value", eq_v.pop_front(), v);
    end
  endtask
  task automatic note(logic [31:0] c, logic [31:0] v);
    eq_c.push_back(c);
    eq_v.push_back(v);
  endtask
  // Second process: the GoodCRC, request, DR_Swap, Hard_Reset and Rx.Detect strobes each take the oldest note
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready && !pwrite) cmp("read", rq.pop_front(), prdata & rm.pop_front());
    if (!presetn) last = -1;
    else begin
      if (cfg_send) begin
        cmp("config out", loc, cfg_out);
        if (last >= 0) cmp("repeat gap", gap + 1, cyc - last);
        last = cyc;
      end
      if (crc) seen(2, {31'h0, drd});
      if (req) seen(3, 0);
      if (drs) seen(4, 0);
      if (hrs) seen(5, {31'h0, bb});
      if (rx) seen(6, 0);
    end
  end
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
    if (i == 20) begin
      n_fail++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m);
    rq.push_back(e);
    rm.push_back(m);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic pulse(int b);
    @(posedge pclk);
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev[b] <= 1'b0;
  endtask
  task automatic start();
    presetn <= 1'b0;
    vconn <= 1'b0;
    vbus <= 1'b0;
    ce <= 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic run(logic d, logic m, logic [1:0] md);
    start();
    gap = 2 + $urandom % 6;
    loc = $urandom;
    dfp <= d;
    mode <= md;
    slow <= $urandom % 2;
    cfg_val <= m ? loc : ~loc;
    caps <= $urandom;
    rd(12'h000, 32'h2710_0001, 32'hFFFF_0001);
    rd(12'h010, 32'h0001_9000, 32'hFFFF_FFFF);
    rd(12'h020, 32'h0001_0000, 32'h00FF_0000);
    apb(1'b1, 12'h0F8, 32'hFFFF_FFFF);
    rd(12'h0F8, 32'h0000_0000, 32'hFFFF_FFFF);
    apb(1'b1, 12'h000, {gap[15:0], 16'h0001});
    apb(1'b1, 12'h008, loc);
    vconn <= 1'b1;
    pulse(0);
    pulse(4);
    pulse(3);
    repeat (3 * gap + 4) @(posedge pclk);
    pulse(1);
    note(2, caps[25]);
    note(3, 0);
    pulse(4);
    if (!d) repeat (md == 2'h2 ? 4 : 1) note(4, 0);
    if (d || md == 2'h0) note(m ? 6 : 5, m ? 0 : 1);
    repeat (600) @(posedge pclk);
    cmp("billboard", !m || !(d || md == 2'h0), bb);
    cmp("left over", 0, eq_c.size());
    rd(12'h014, 32'h1300_0000, 32'hFFFF_FFFF);
  endtask
  initial begin
    void'($urandom(70214));
    run(1'b1, 1'b1, 2'h0);
    run(1'b1, 1'b0, 2'h0);
    run(1'b0, 1'b1, 2'h0);
    run(1'b0, 1'b1, 2'h1);
    run(1'b0, 1'b1, 2'h2);
    start();
    @(posedge pclk);
    // Writes while the clock enable is low must be lost
    ce <= 1'b0;
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    ce <= 1'b1;
    rd(12'h008, 32'h0000_0000, 32'hFFFF_FFFF);
    mode <= 2'h3;
    vconn <= 1'b1;
    repeat (210) @(posedge pclk);
    note(4, 0);
    note(5, 1);
    pulse(2);
    repeat (560) @(posedge pclk);
    cmp("watchdog", 1, bb);
    cmp("left over", 0, eq_c.size());
    start();
    vconn <= 1'b1;
    vbus <= 1'b1;
    repeat (990) @(posedge pclk);
    note(5, 0);
    repeat (30) @(posedge pclk);
    cmp("left over", 0, eq_c.size());
    start();
    vconn <= 1'b1;
    repeat (260) @(posedge pclk);
    pulse(0);
    repeat (3) @(posedge pclk);
    cmp("detach open", 1, cc);
    repeat (250) @(posedge pclk);
    cmp("detach ends", 0, cc);
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end
endmodule // cable_slave_plug_config_fsm_tb
bind plug_cfg_fsm plug_cfg_fsm_asserts chk (.pclk(pclk), .presetn(presetn),
  .src_caps_object(src_caps_object), .good_crc_send(good_crc_send),
  .request_send(request_send), .request_object(request_object), .sink_pdo(sink_pdo),
  .local_drd(local_drd), .swap_reject(swap_reject), .hard_reset_send(hard_reset_send),
  .billboard_invalid(billboard_invalid), .cc_open(cc_open), .vconn_open(vconn_open),
  .rx_detect_start(rx_detect_start));
